// ---- hdl/space_decoder_consts.vh ----
// constants for the data and program space decoder
// included by the decoder and the return stack; definitions only
`ifndef SPACE_DECODER_CONSTS_VH
`define SPACE_DECODER_CONSTS_VH
// ----------------------------------------
// program space
// ----------------------------------------
`define PROG_AW 12
`define VEC_IRQ_BASE 12'hff0
`define VEC_IRQ_TOP 12'hff7
`define VEC_NMI 12'hffc
`define VEC_RESET 12'hffe
`define STACK_DEPTH 6
// ----------------------------------------
// data space regions
// ----------------------------------------
`define BANK_TOP 8'h3f
`define WIN_BASE 8'h40
`define WIN_TOP 8'h7f
`define CORE_BASE 8'h80
`define CORE_TOP 8'h83
`define RAM_BASE 8'h84
`define RAM_TOP 8'hbf
`define PORT_DATA_BASE 8'hc0
`define PORT_DATA_TOP 8'hc2
`define PORT_DIR_BASE 8'hc4
`define PORT_DIR_TOP 8'hc6
`define IRQ_OPT_ADDR 8'hc8
`define WINDOW_BASE_ADDR 8'hc9
`define PORT_OPT_BASE 8'hcc
`define PORT_OPT_TOP 8'hce
`define ADC_BASE 8'hd0
`define ADC_TOP 8'hd1
`define TIMER_BASE 8'hd2
`define TIMER_TOP 8'hd4
`define ART_A_BASE 8'hd5
`define ART_A_TOP 8'hd7
`define WDOG_ADDR 8'hd8
`define ART_B_BASE 8'hd9
`define ART_B_TOP 8'hdb
`define OSC_ADDR 8'hdc
`define MISC_ADDR 8'hdd
`define SERIAL_BASE 8'he0
`define SERIAL_TOP 8'he2
`define PAGE_SELECT_ADDR 8'he8
`define EE_CTRL_ADDR 8'hea
`define ACC_ADDR 8'hff
// ----------------------------------------
// field positions
// ----------------------------------------
`define WIN_BASE_W 6
`define WIN_OFS_W 6
`define PAGE_RAM_BIT 4
`define PAGE_EE1_BIT 1
`define PAGE_EE0_BIT 0
// ----------------------------------------
// select one-hot positions
// ----------------------------------------
`define SEL_W 20
`define S_RAM_PAGE 0
`define S_EE_PAGE0 1
`define S_EE_PAGE1 2
`define S_WINDOW 3
`define S_CORE 4
`define S_RAM 5
`define S_PORT_DATA 6
`define S_PORT_DIR 7
`define S_IRQ_OPT 8
`define S_PORT_OPT 9
`define S_ADC 10
`define S_TIMER 11
`define S_ART 12
`define S_WDOG 13
`define S_OSC 14
`define S_MISC 15
`define S_SERIAL 16
`define S_PAGE_SEL 17
`define S_EE_CTRL 18
`define S_ACC 19
`endif

// ---- hdl/return_stack.v ----
// six deep hardware stack of return addresses
// push and pop are one-cycle strobes from the core; never both at once
`timescale 1ns/1ps
`default_nettype none
`include "space_decoder_consts.vh"
module return_stack #(
    parameter DEPTH = `STACK_DEPTH,
    parameter AW = `PROG_AW
) (
    input wire clk,
    input wire rst_n,
    input wire push,
    input wire pop,
    input wire [AW-1:0] push_addr,
    output reg [AW-1:0] top_addr,
    output reg [2:0] level
);
    reg [AW-1:0] mem [0:DEPTH-1];
    integer i;
    // ----------------------------------------
    // shift stack, oldest entry lost on overflow like the core expects
    // ----------------------------------------
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (i = 0; i < DEPTH; i = i + 1) begin
                mem[i] <= {AW{1'b0}};
            end
            top_addr <= {AW{1'b0}};
            level <= 3'h0;
        end else if (push) begin
            mem[0] <= push_addr;
            for (i = 1; i < DEPTH; i = i + 1) begin
                mem[i] <= mem[i-1];
            end
            top_addr <= push_addr;
            if (level != DEPTH[2:0]) begin
                level <= level + 3'h1;
            end
        end else if (pop) begin
            for (i = 0; i < DEPTH - 1; i = i + 1) begin
                mem[i] <= mem[i+1];
            end
            mem[DEPTH-1] <= {AW{1'b0}};
            top_addr <= mem[1];
            if (level != 3'h0) begin
                level <= level - 3'h1;
            end
        end
    end
endmodule // return_stack
`default_nettype wire

// ---- hdl/space_decoder.v ----
// program and data space decoder with window and page registers
// core drives addresses and strobes synchronous to clk; memories answer one cycle later
`timescale 1ns/1ps
`default_nettype none
`include "space_decoder_consts.vh"
module space_decoder #(
    parameter EE_PAGES = 2,
    parameter AW = `PROG_AW
) (
    input wire clk,
    input wire rst_n,
    input wire readout_protect,
    input wire ext_read_req,
    input wire [AW-1:0] ext_read_addr,
    input wire [AW-1:0] fetch_addr,
    input wire fetch_req,
    input wire [2:0] vector_sel,
    input wire vector_req,
    input wire push,
    input wire pop,
    input wire [AW-1:0] push_addr,
    input wire [7:0] data_addr,
    input wire data_rd,
    input wire data_wr,
    input wire [7:0] data_wdata,
    input wire [7:0] prog_rdata,
    output reg [AW-1:0] prog_addr,
    output reg prog_rd,
    output reg [7:0] ext_read_data,
    output reg ext_read_valid,
    output reg [7:0] data_rdata,
    output reg data_rvalid,
    output reg [`SEL_W-1:0] sel,
    output reg sel_wr,
    output reg sel_rd,
    output reg [5:0] sel_offset,
    output reg [7:0] sel_wdata,
    output reg [`WIN_BASE_W-1:0] rom_window_base,
    output reg [2:0] page_map,
    output reg [AW-1:0] return_addr,
    output reg [2:0] stack_level
);
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function in_range;
        input [7:0] a;
        input [7:0] lo;
        input [7:0] hi;
        begin
            in_range = (a >= lo) && (a <= hi);
        end
    endfunction

    // ----------------------------------------
    // page and window registers, deliberately outside reset
    // ----------------------------------------
    reg [`WIN_BASE_W-1:0] win_base_reg;
    reg [7:0] page_select_reg;
    wire win_base_we;
    wire page_sel_we;
    assign win_base_we = data_wr && (data_addr == `WINDOW_BASE_ADDR);
    assign page_sel_we = data_wr && (data_addr == `PAGE_SELECT_ADDR);

    // no reset: software must load both before first use
    always @(posedge clk) begin
        if (win_base_we) begin
            win_base_reg <= data_wdata[`WIN_BASE_W-1:0];
        end
        if (page_sel_we) begin
            page_select_reg <= data_wdata;
        end
    end

    // ----------------------------------------
    // data address decode
    // ----------------------------------------
    reg [`SEL_W-1:0] sel_next;
    reg ee0_ok;
    reg ee1_ok;
    always @* begin
        sel_next = {`SEL_W{1'b0}};
        ee0_ok = (EE_PAGES >= 1);
        ee1_ok = (EE_PAGES >= 2);
        if (data_addr <= `BANK_TOP) begin
            // more than one bit set enables pages in parallel, as the silicon does
            sel_next[`S_RAM_PAGE] = page_select_reg[`PAGE_RAM_BIT];
            sel_next[`S_EE_PAGE0] = page_select_reg[`PAGE_EE0_BIT] & ee0_ok;
            sel_next[`S_EE_PAGE1] = page_select_reg[`PAGE_EE1_BIT] & ee1_ok;
        end
        sel_next[`S_WINDOW] = in_range(data_addr, `WIN_BASE, `WIN_TOP);
        sel_next[`S_CORE] = in_range(data_addr, `CORE_BASE, `CORE_TOP);
        sel_next[`S_RAM] = in_range(data_addr, `RAM_BASE, `RAM_TOP);
        sel_next[`S_ACC] = (data_addr == `ACC_ADDR);
        sel_next[`S_PORT_DATA] = in_range(data_addr, `PORT_DATA_BASE, `PORT_DATA_TOP);
        sel_next[`S_PORT_DIR] = in_range(data_addr, `PORT_DIR_BASE, `PORT_DIR_TOP);
        sel_next[`S_PORT_OPT] = in_range(data_addr, `PORT_OPT_BASE, `PORT_OPT_TOP);
        sel_next[`S_IRQ_OPT] = (data_addr == `IRQ_OPT_ADDR);
        sel_next[`S_ADC] = in_range(data_addr, `ADC_BASE, `ADC_TOP);
        sel_next[`S_TIMER] = in_range(data_addr, `TIMER_BASE, `TIMER_TOP);
        sel_next[`S_ART] = in_range(data_addr, `ART_A_BASE, `ART_A_TOP)
            || in_range(data_addr, `ART_B_BASE, `ART_B_TOP);
        sel_next[`S_WDOG] = (data_addr == `WDOG_ADDR);
        sel_next[`S_OSC] = (data_addr == `OSC_ADDR);
        sel_next[`S_MISC] = (data_addr == `MISC_ADDR);
        sel_next[`S_SERIAL] = in_range(data_addr, `SERIAL_BASE, `SERIAL_TOP);
        sel_next[`S_EE_CTRL] = (data_addr == `EE_CTRL_ADDR) && ee0_ok;
        sel_next[`S_PAGE_SEL] = (data_addr == `PAGE_SELECT_ADDR);
    end

    // write-only slots never raise a read strobe; window never raises a write
    wire wr_blocked;
    wire rd_blocked;
    assign wr_blocked = sel_next[`S_WINDOW];
    assign rd_blocked = sel_next[`S_IRQ_OPT] | (data_addr == `WINDOW_BASE_ADDR)
        | sel_next[`S_PAGE_SEL];

    // ----------------------------------------
    // program memory port arbitration
    // ----------------------------------------
    // priority: vector, fetch, window read, external readout
    reg [AW-1:0] prog_addr_next;
    reg prog_rd_next;
    reg win_rd_next;
    reg ext_rd_next;
    always @* begin
        prog_addr_next = prog_addr;
        prog_rd_next = 1'b0;
        win_rd_next = 1'b0;
        ext_rd_next = 1'b0;
        if (vector_req) begin
            prog_rd_next = 1'b1;
            if (vector_sel[2]) begin
                prog_addr_next = vector_sel[0] ? `VEC_RESET : `VEC_NMI;
            end else begin
                prog_addr_next = `VEC_IRQ_BASE | {{(AW-3){1'b0}}, vector_sel[1:0], 1'b0};
            end
        end else if (fetch_req) begin
            prog_rd_next = 1'b1;
            prog_addr_next = fetch_addr;
        end else if (data_rd && sel_next[`S_WINDOW]) begin
            prog_rd_next = 1'b1;
            win_rd_next = 1'b1;
            prog_addr_next = {win_base_reg, data_addr[`WIN_OFS_W-1:0]};
        end else if (ext_read_req && !readout_protect) begin
            prog_rd_next = 1'b1;
            ext_rd_next = 1'b1;
            prog_addr_next = ext_read_addr;
        end
    end

    // ----------------------------------------
    // registered outputs
    // ----------------------------------------
    reg win_issue;
    reg ext_issue;
    reg win_pending;
    reg ext_pending;
    reg [2:0] page_map_next;
    reg sel_wr_next;
    reg sel_rd_next;
    always @* begin
        page_map_next = {page_select_reg[`PAGE_RAM_BIT],
            page_select_reg[`PAGE_EE1_BIT] & ee1_ok, page_select_reg[`PAGE_EE0_BIT] & ee0_ok};
    end

    // a slot strobe needs a decoded slot; window writes and write-only reads are dropped
    always @* begin
        sel_wr_next = data_wr && !wr_blocked && (sel_next != {`SEL_W{1'b0}});
        sel_rd_next = data_rd && !rd_blocked && !sel_next[`S_WINDOW]
            && (sel_next != {`SEL_W{1'b0}});
    end

    // ----------------------------------------
    // program port
    // ----------------------------------------
    // address holds between reads so the memory bus stays quiet
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prog_addr <= {AW{1'b0}};
            prog_rd <= 1'b0;
        end else begin
            prog_addr <= prog_addr_next;
            prog_rd <= prog_rd_next;
        end
    end

    // ----------------------------------------
    // read data return
    // ----------------------------------------
    // memory answers the cycle after the strobe, so data are caught two edges after issue
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            win_issue <= 1'b0;
            ext_issue <= 1'b0;
            win_pending <= 1'b0;
            ext_pending <= 1'b0;
            data_rdata <= 8'h00;
            data_rvalid <= 1'b0;
            ext_read_data <= 8'h00;
            ext_read_valid <= 1'b0;
        end else begin
            win_issue <= win_rd_next;
            ext_issue <= ext_rd_next;
            win_pending <= win_issue;
            ext_pending <= ext_issue;
            data_rvalid <= win_pending;
            if (win_pending) begin
                data_rdata <= prog_rdata;
            end
            ext_read_valid <= ext_pending;
            // blocked readouts never issue; zero only marks idle cycles
            ext_read_data <= ext_pending ? prog_rdata : 8'h00;
        end
    end

    // ----------------------------------------
    // slot strobes
    // ----------------------------------------
    // offset and data follow every cycle; only the strobes qualify them
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sel <= {`SEL_W{1'b0}};
            sel_wr <= 1'b0;
            sel_rd <= 1'b0;
            sel_offset <= 6'h00;
            sel_wdata <= 8'h00;
        end else begin
            sel <= sel_next;
            sel_wr <= sel_wr_next;
            sel_rd <= sel_rd_next;
            sel_offset <= data_addr[5:0];
            sel_wdata <= data_wdata;
        end
    end

    // ----------------------------------------
    // register copies
    // ----------------------------------------
    // copies show zero in reset, then follow the unreset registers
    // software loads the registers; reset leaves them as they were
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rom_window_base <= {`WIN_BASE_W{1'b0}};
            page_map <= 3'h0;
        end else begin
            rom_window_base <= win_base_reg;
            page_map <= page_map_next;
        end
    end

    // ----------------------------------------
    // return stack
    // ----------------------------------------
    wire [AW-1:0] stack_top;
    wire [2:0] stack_lvl;
    return_stack #(
        .DEPTH(`STACK_DEPTH),
        .AW(AW)
    ) u_stack (
        .clk(clk),
        .rst_n(rst_n),
        .push(push),
        .pop(pop),
        .push_addr(push_addr),
        .top_addr(stack_top),
        .level(stack_lvl)
    );

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            return_addr <= {AW{1'b0}};
            stack_level <= 3'h0;
        end else begin
            return_addr <= stack_top;
            stack_level <= stack_lvl;
        end
    end
endmodule // space_decoder
`default_nettype wire

// ---- verif/space_decoder_monitor.sv ----
// checker of the decoder's port behaviour
// assumes the consts header on the include path and one clock domain
`timescale 1ns/1ps
`default_nettype none
`include "space_decoder_consts.vh"
module space_decoder_monitor #(
    parameter EE_PAGES = 2
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic readout_protect,
    input wire logic ext_read_req,
    input wire logic fetch_req,
    input wire logic [11:0] fetch_addr,
    input wire logic vector_req,
    input wire logic [2:0] vector_sel,
    input wire logic [7:0] data_addr,
    input wire logic data_rd,
    input wire logic data_wr,
    input wire logic [7:0] data_wdata,
    input wire logic [7:0] prog_rdata,
    input wire logic [11:0] prog_addr,
    input wire logic prog_rd,
    input wire logic ext_read_valid,
    input wire logic [7:0] data_rdata,
    input wire logic data_rvalid,
    input wire logic [19:0] sel,
    input wire logic sel_wr,
    input wire logic sel_rd,
    input wire logic [5:0] rom_window_base,
    input wire logic [2:0] page_map
);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire in_win = data_addr >= `WIN_BASE && data_addr <= `WIN_TOP;
    wire win_rd = data_rd && in_win && !fetch_req && !vector_req;
    // upper window bits checked in tb: internal base leads the output copy
    property p_win_rd; win_rd |=> prog_rd && prog_addr[5:0] == $past(data_addr[5:0]); endproperty
    a_win_rd: assert property (p_win_rd) else $error("window address wrong");
    property p_win_dat; win_rd |-> ##3 data_rvalid && data_rdata == $past(prog_rdata); endproperty
    a_win_dat: assert property (p_win_dat) else $error("window data wrong");
    property p_fetch; fetch_req && !vector_req |=> prog_rd && prog_addr == $past(fetch_addr); endproperty
    a_fetch: assert property (p_fetch) else $error("fetch address wrong");
    property p_vec;
        vector_req && !(vector_sel[2] && vector_sel[1]) |=> prog_addr == ($past(vector_sel[2]) ?
            {10'h3ff, $past(vector_sel[0]), 1'b0} : {9'h1fe, $past(vector_sel[1:0]), 1'b0});
    endproperty
    a_vec: assert property (p_vec) else $error("vector address wrong");
    property p_ext_block; ext_read_req && readout_protect |-> ##3 !ext_read_valid; endproperty
    a_ext_block: assert property (p_ext_block) else $error("protected readout answered");
    property p_win_wr; data_wr && in_win |=> !sel_wr; endproperty
    a_win_wr: assert property (p_win_wr) else $error("window write passed");
    property p_wo_rd;
        data_rd && (data_addr == `IRQ_OPT_ADDR || data_addr == `WINDOW_BASE_ADDR ||
            data_addr == `PAGE_SELECT_ADDR) |=> !sel_rd;
    endproperty
    a_wo_rd: assert property (p_wo_rd) else $error("write-only read passed");
    property p_base_wr;
        data_wr && data_addr == `WINDOW_BASE_ADDR |-> ##2 rom_window_base == $past(data_wdata[5:0], 2);
    endproperty
    a_base_wr: assert property (p_base_wr) else $error("window base wrong");
    property p_page_wr;
        data_wr && data_addr == `PAGE_SELECT_ADDR |-> ##2 page_map == {$past(data_wdata[4], 2),
            $past(data_wdata[1], 2) && EE_PAGES > 1, $past(data_wdata[0], 2) && EE_PAGES > 0};
    endproperty
    a_page_wr: assert property (p_page_wr) else $error("page map wrong");
    property p_acc; data_addr == `ACC_ADDR |=> sel == 20'h1 << `S_ACC; endproperty
    a_acc: assert property (p_acc) else $error("accumulator decode wrong");
    property p_resv; data_addr == 8'hc3 |=> sel == 20'h0 && !sel_rd && !sel_wr; endproperty
    a_resv: assert property (p_resv) else $error("reserved slot decoded");
    c_win: cover property (win_rd);
    c_page: cover property (data_wr && data_addr == `PAGE_SELECT_ADDR);
    c_block: cover property (ext_read_req && readout_protect);
endmodule // space_decoder_monitor
bind space_decoder space_decoder_monitor #(.EE_PAGES(EE_PAGES)) space_decoder_monitor_inst (
    .clk(clk), .rst_n(rst_n), .readout_protect(readout_protect), .ext_read_req(ext_read_req),
    .fetch_req(fetch_req), .fetch_addr(fetch_addr), .vector_req(vector_req), .vector_sel(vector_sel),
    .data_addr(data_addr), .data_rd(data_rd), .data_wr(data_wr), .data_wdata(data_wdata),
    .prog_rdata(prog_rdata), .prog_addr(prog_addr), .prog_rd(prog_rd), .ext_read_valid(ext_read_valid),
    .data_rdata(data_rdata), .data_rvalid(data_rvalid), .sel(sel), .sel_wr(sel_wr), .sel_rd(sel_rd),
    .rom_window_base(rom_window_base), .page_map(page_map));
`default_nettype wire

// ---- verif/prog_mem_model.sv ----
// program memory seen by the decoder
// answers the cycle after a read strobe; no write path exists
`timescale 1ns/1ps
`default_nettype none
module prog_mem_model (
    input wire logic clk,
    input wire logic prog_rd,
    input wire logic [11:0] prog_addr,
    output logic [7:0] prog_rdata
);
    initial prog_rdata = 8'h00;
    // idle data toggles so stale bytes never look valid
    always @(posedge clk) begin
        if (prog_rd) begin
            prog_rdata <= prog_addr[7:0] ^ {prog_addr[11:8], prog_addr[11:8]};
        end else begin
            prog_rdata <= ~prog_rdata;
        end
    end
endmodule // prog_mem_model
`default_nettype wire

// ---- verif/tb_space_decoder.sv ----
// self-checking bench of the decoder
// assumes the memory model and checker files compiled before it
`timescale 1ns/1ps
`default_nettype none
`include "space_decoder_consts.vh"
module tb_space_decoder;
    logic clk = 0, rst_n = 0, readout_protect = 0, ext_read_req = 0, fetch_req = 0, vector_req = 0;
    logic push = 0, pop = 0, data_rd = 0, data_wr = 0, prog_rd, ext_read_valid, data_rvalid, sel_wr, sel_rd;
    logic pr, rv, sr;
    logic [14:0] ws;
    logic [11:0] ext_read_addr = 0, fetch_addr = 0, push_addr = 0, prog_addr, return_addr, pa;
    logic [7:0] data_addr = 0, data_wdata = 0, prog_rdata, ext_read_data, data_rdata, rdd, v;
    logic [2:0] vector_sel = 0, page_map, stack_level;
    logic [19:0] sel, rs;
    logic [5:0] rom_window_base, sel_offset;
    logic [7:0] sel_wdata;
    int failures = 0, comparisons = 0, i;
    byte unsigned dec_a[8] = '{8'h80, 8'hbf, 8'hc4, 8'hce, 8'hd7, 8'hdc, 8'he2, 8'hea};
    int dec_s[8] = '{`S_CORE, `S_RAM, `S_PORT_DIR, `S_PORT_OPT, `S_ART, `S_OSC, `S_SERIAL, `S_EE_CTRL};
    space_decoder #(.EE_PAGES(2)) space_decoder_inst (
        .clk(clk), .rst_n(rst_n), .readout_protect(readout_protect), .ext_read_req(ext_read_req),
        .ext_read_addr(ext_read_addr), .fetch_addr(fetch_addr), .fetch_req(fetch_req), .vector_sel(vector_sel),
        .vector_req(vector_req), .push(push), .pop(pop), .push_addr(push_addr), .data_addr(data_addr),
        .data_rd(data_rd), .data_wr(data_wr), .data_wdata(data_wdata), .prog_rdata(prog_rdata),
        .prog_addr(prog_addr), .prog_rd(prog_rd), .ext_read_data(ext_read_data), .ext_read_valid(ext_read_valid),
        .data_rdata(data_rdata), .data_rvalid(data_rvalid), .sel(sel), .sel_wr(sel_wr), .sel_rd(sel_rd),
        .sel_offset(sel_offset), .sel_wdata(sel_wdata), .rom_window_base(rom_window_base), .page_map(page_map),
        .return_addr(return_addr), .stack_level(stack_level));
    prog_mem_model prog_mem_model_inst (.clk(clk), .prog_rd(prog_rd), .prog_addr(prog_addr), .prog_rdata(prog_rdata));
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    initial forever #2 clk = ~clk;
    function automatic logic [7:0] mem(input logic [11:0] a);
        return a[7:0] ^ {a[11:8], a[11:8]};
    endfunction
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic results;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1 data_addr = a;
        data_wdata = d;
        data_wr = 1;
        @(posedge clk);
        #1 data_wr = 0;
        ws = {sel_wr, sel_offset, sel_wdata};
        repeat (2) @(posedge clk);
        #1;
    endtask
    // k: 0 data read, 1 external readout, 2 fetch, 3 vector
    task automatic req(input int k, input logic [11:0] a);
        @(posedge clk);
        #1;
        case (k)
            0: begin data_addr = a[7:0]; data_rd = 1; end
            1: begin ext_read_addr = a; ext_read_req = 1; end
            2: begin fetch_addr = a; fetch_req = 1; end
            default: begin vector_sel = a[2:0]; vector_req = 1; end
        endcase
        @(posedge clk);
        #1 {data_rd, ext_read_req, fetch_req, vector_req} = 4'h0;
        pa = prog_addr;
        pr = prog_rd;
        rs = sel;
        sr = sel_rd;
        repeat (2) @(posedge clk);
        #1 rv = k == 0 ? data_rvalid : ext_read_valid;
        rdd = k == 0 ? data_rdata : ext_read_data;
    endtask
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        #20000 failures++;
        results();
    end
    initial begin
        repeat (16) @(posedge clk);
        #1 rst_n = 1;
        wr(8'hc9, 8'he8);
        chk(rom_window_base, 6'h28);
        req(0, 12'h059);
        chk(pa, 12'ha19);
        chk({rv, rdd}, {1'b1, mem(12'ha19)});
        wr(8'h59, 8'h55);
        chk(ws[14], 1'b0);
        req(0, 12'h0c9);
        chk({pr, sr}, 2'b00);
        req(0, 12'h0c3);
        chk({sr, rs}, 21'h0);
        wr(8'hc1, 8'h5a);
        chk(ws, {1'b1, 6'h01, 8'h5a});
        for (i = 0; i < 5; i++) begin
            v = i < 3 ? 8'h01 << (i * 2 - (i == 2 ? 0 : i)) : (i == 3 ? 8'h00 : 8'hff);
            wr(8'he8, v);
            chk(page_map, {v[4], v[1], v[0]});
            req(0, 12'h010);
            chk(rs[2:0], {v[1], v[0], v[4]});
        end
        for (i = 0; i < 8; i++) begin
            req(0, {4'h0, dec_a[i]});
            chk({sr, rs}, {1'b1, 20'h1 << dec_s[i]});
        end
        for (i = 0; i < 6; i++) begin
            req(3, 12'(i));
            chk(pa, i < 4 ? 12'(12'hff0 | (i << 1)) : (i == 4 ? 12'hffc : 12'hffe));
        end
        req(2, 12'hfff);
        chk({pr, pa}, {1'b1, 12'hfff});
        readout_protect = 1;
        req(1, 12'h123);
        chk({pr, rv}, 2'b00);
        readout_protect = 0;
        req(1, 12'h123);
        chk({rv, rdd}, {1'b1, mem(12'h123)});
        @(posedge clk);
        #1 push = 1;
        for (i = 1; i < 8; i++) begin
            push_addr = 12'(12'h100 + i);
            @(posedge clk);
            #1;
        end
        push = 0;
        @(posedge clk);
        #1 chk({stack_level, return_addr}, {3'd6, 12'h107});
        pop = 1;
        @(posedge clk);
        #1 pop = 0;
        @(posedge clk);
        #1 chk({stack_level, return_addr}, {3'd5, 12'h106});
        rst_n = 0;
        repeat (2) @(posedge clk);
        #1 rst_n = 1;
        req(0, 12'h040);
        chk({rom_window_base, pa}, {6'h28, 12'ha00});
        results();
    end
endmodule // tb_space_decoder
`default_nettype wire
